// file: design/adc_ctrl_regs.sv
// control, gain and threshold registers with sync handling and filter_settled_flag tracking
`timescale 1ns/1ps

// Overview of operation
// - Reads work from start-up with default gain and threshold, but data is invalid until the filter settles.
// - The settled flag is raised once the filter settling time has elapsed.
// - A write carries an address and a 16-bit word that is loaded into the addressed register.
// - The control register lives at address 0x0001, resets to zero and holds the documented controls.
// - Gain and threshold registers store what is written and return it on read.
// - Control bits 14, 13 and 11 make the next read return threshold, gain or status.
// - Control bit 9 starts internal sync; it and the read selects clear themselves after use.
// - Control bit 3 powers down without losing state, and clearing it powers back up.
module adc_ctrl_regs #(
    parameter int          SETTLE_CYCLES = adc_ctrl_pkg::SETTLE_DEF,
    parameter logic        PART_BIT      = 1'b1  // arbitrary value
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // sync pin from the host, active low
    input  wire logic        sync_n,
    // register write port
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_addr,
    input  wire logic [15:0] wr_data,
    // read port
    input  wire logic        rd_en,
    input  wire logic [31:0] conv_word,
    output logic      [31:0] rd_data,
    output logic             rd_valid,
    // converter state inputs
    input  wire logic        overrange_in,
    input  wire logic [1:0]  dec_rate,
    // control outputs
    output logic             filter_settled_flag,
    output logic             power_off_request,
    output logic             low_power_flag,
    output logic             ref_buffer_off,
    output logic             ref_bypass,
    output logic             amplifier_disable,
    output logic             filter_restart,
    output logic      [15:0] gain_value,
    output logic      [15:0] threshold_value
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:0]  rd_sel;      // threshold, gain, status
        logic [15:0] gain;
        logic [15:0] thresh;
        logic [31:0] settle_cnt;
        logic        settled;
        logic [2:0]  sync_low;
        logic        restart;
        logic [31:0] rd_data;
        logic        rd_valid;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [15:0] status_word;

    if (SETTLE_CYCLES < 1)
    begin : g_chk
        $error("SETTLE_CYCLES must be at least one");
    end

    // status word assembled from live state
    always_comb
    begin
        status_word = 16'h0000;
        status_word[adc_ctrl_pkg::SB_PART]      = PART_BIT;
        status_word[adc_ctrl_pkg::SB_ONE_HI]    = 1'b1;
        status_word[adc_ctrl_pkg::SB_SETTLED]   = s_q.settled;
        status_word[adc_ctrl_pkg::SB_OVR]       = overrange_in;
        status_word[adc_ctrl_pkg::SB_ONE_LO]    = 1'b1;
        status_word[adc_ctrl_pkg::SB_REF_ON]    = ~s_q.ctrl[adc_ctrl_pkg::CB_REF_OFF];
        status_word[adc_ctrl_pkg::SB_AMP_ON]    = ~s_q.ctrl[adc_ctrl_pkg::CB_AMPLIFIER_DISABLE];
        status_word[adc_ctrl_pkg::SB_LOW_POWER] = s_q.ctrl[adc_ctrl_pkg::CB_LOW_POWER];
        status_word[adc_ctrl_pkg::SB_DEC +: 2]  = dec_rate;
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        s_d          = s_q;
        s_d.restart  = 1'b0;
        s_d.rd_valid = 1'b0;
        // sync pin: count low cycles, act on the rising edge if the pulse was long enough
        if (!sync_n)
        begin
            if (s_q.sync_low != adc_ctrl_pkg::SYNC_CNT_TOP)
                s_d.sync_low = s_q.sync_low + 3'd1;
        end
        else
        begin
            s_d.sync_low = 3'd0;
            if (s_q.sync_low == adc_ctrl_pkg::SYNC_CNT_TOP)
                s_d.restart = 1'b1;
        end
        // register writes; a write outranks a pending read of the select
        if (wr_en)
        begin
            case (wr_addr)
                adc_ctrl_pkg::ADDR_CONTROL:
                begin
                    s_d.ctrl   = wr_data & adc_ctrl_pkg::CONTROL_KEEP;
                    s_d.rd_sel = {wr_data[adc_ctrl_pkg::CB_RD_THRESH],
                                  wr_data[adc_ctrl_pkg::CB_RD_GAIN],
                                  wr_data[adc_ctrl_pkg::CB_RD_STATUS]};
                    if (wr_data[adc_ctrl_pkg::CB_SYNC])
                        s_d.restart = 1'b1;
                end
                adc_ctrl_pkg::ADDR_GAIN:      s_d.gain   = wr_data;
                adc_ctrl_pkg::ADDR_THRESHOLD: s_d.thresh = wr_data;
                default:                      ;
            endcase
        end
        else if (rd_en)
        begin
            // one read consumes the select; highest bit wins if the host set several
            s_d.rd_valid = 1'b1;
            s_d.rd_sel   = 3'b000;
            if (s_q.rd_sel[2])
                s_d.rd_data = {16'h0000, s_q.thresh};
            else if (s_q.rd_sel[1])
                s_d.rd_data = {16'h0000, s_q.gain};
            else if (s_q.rd_sel[0])
                s_d.rd_data = {16'h0000, status_word};
            else
                s_d.rd_data = conv_word;
        end
        // settling: restart clears the flag, power-down freezes the count but keeps it
        if (s_d.restart)
        begin
            s_d.settle_cnt = 32'd0;
            s_d.settled    = 1'b0;
        end
        else if (!s_q.ctrl[adc_ctrl_pkg::CB_POWER_OFF_REQUEST] && !s_q.settled)
        begin
            s_d.settle_cnt = s_q.settle_cnt + 32'd1;
            if (s_d.settle_cnt == 32'(SETTLE_CYCLES))
                s_d.settled = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q            <= '0;
            s_q.ctrl       <= adc_ctrl_pkg::CONTROL_RESET;
            s_q.gain       <= adc_ctrl_pkg::GAIN_RESET;
            s_q.thresh     <= adc_ctrl_pkg::THRESH_RESET;
        end
        else
            s_q <= s_d;
    end

    // outputs straight from the state register
    assign rd_data             = s_q.rd_data;
    assign rd_valid            = s_q.rd_valid;
    assign filter_settled_flag = s_q.settled;
    assign power_off_request   = s_q.ctrl[adc_ctrl_pkg::CB_POWER_OFF_REQUEST];
    assign low_power_flag      = s_q.ctrl[adc_ctrl_pkg::CB_LOW_POWER];
    assign ref_buffer_off      = s_q.ctrl[adc_ctrl_pkg::CB_REF_OFF];
    assign ref_bypass          = s_q.ctrl[adc_ctrl_pkg::CB_BYPASS];
    assign amplifier_disable   = s_q.ctrl[adc_ctrl_pkg::CB_AMPLIFIER_DISABLE];
    assign filter_restart      = s_q.restart;
    assign gain_value          = s_q.gain;
    assign threshold_value     = s_q.thresh;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_ctrl_wr_sync;
        wr_en && wr_addr == adc_ctrl_pkg::ADDR_CONTROL && wr_data[adc_ctrl_pkg::CB_SYNC];
    endsequence
    sequence s_long_low;
        !sync_n [*4] ##1 sync_n;
    endsequence

    property p_sync_bit;
        @(posedge clk) disable iff (!arst_n) s_ctrl_wr_sync |=> filter_restart && !filter_settled_flag;
    endproperty
    a_sync_bit: assert property (p_sync_bit) else $error("sync bit did not restart filter");

    property p_sync_pin;
        @(posedge clk) disable iff (!arst_n) s_long_low |=> filter_restart;
    endproperty
    a_sync_pin: assert property (p_sync_pin) else $error("long sync pulse ignored");

    property p_short_sync;
        @(posedge clk) disable iff (!arst_n)
            sync_n ##1 !sync_n [*3] ##1 sync_n
            ##0 !(wr_en && wr_addr == adc_ctrl_pkg::ADDR_CONTROL && wr_data[adc_ctrl_pkg::CB_SYNC])
            |=> !filter_restart;
    endproperty
    a_short_sync: assert property (p_short_sync) else $error("short sync pulse accepted");

    property p_gain_store;
        @(posedge clk) disable iff (!arst_n)
            wr_en && wr_addr == adc_ctrl_pkg::ADDR_GAIN |=> gain_value == $past(wr_data);
    endproperty
    a_gain_store: assert property (p_gain_store) else $error("gain not stored");

    property p_ctrl_store;
        @(posedge clk) disable iff (!arst_n)
            wr_en && wr_addr == adc_ctrl_pkg::ADDR_CONTROL
            |=> power_off_request == $past(wr_data[adc_ctrl_pkg::CB_POWER_OFF_REQUEST])
                && amplifier_disable == $past(wr_data[adc_ctrl_pkg::CB_AMPLIFIER_DISABLE]);
    endproperty
    a_ctrl_store: assert property (p_ctrl_store) else $error("control bits not stored");

    property p_read_gain;
        @(posedge clk) disable iff (!arst_n)
            wr_en && wr_addr == adc_ctrl_pkg::ADDR_CONTROL && wr_data[adc_ctrl_pkg::CB_RD_GAIN]
            && !wr_data[adc_ctrl_pkg::CB_RD_THRESH]
            ##1 (!wr_en && !rd_en) ##1 (rd_en && !wr_en) |=> rd_valid && rd_data[15:0] == gain_value;
    endproperty
    a_read_gain: assert property (p_read_gain) else $error("gain select not honoured");

    property p_select_clears;
        @(posedge clk) disable iff (!arst_n)
            // exactly one cycle without a write stands between the two reads
            rd_en && !wr_en ##1 !wr_en ##1 rd_en && !wr_en |=> rd_data == $past(conv_word);
    endproperty
    a_select_clears: assert property (p_select_clears) else $error("read select stuck");

    property p_settle_hold;
        @(posedge clk) disable iff (!arst_n)
            filter_settled_flag ##1 !filter_restart |-> filter_settled_flag;
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settled flag dropped without restart");

    property p_powerdown_freeze;
        @(posedge clk) disable iff (!arst_n)
            power_off_request && !filter_restart |=> filter_restart || $stable(s_q.settle_cnt);
    endproperty
    a_powerdown_freeze: assert property (p_powerdown_freeze) else $error("count ran in power-down");

    property p_settle_time;
        @(posedge clk) disable iff (!arst_n)
            $rose(filter_settled_flag) |-> s_q.settle_cnt == 32'(SETTLE_CYCLES);
    endproperty
    a_settle_time: assert property (p_settle_time) else $error("settled at wrong count");
endmodule

// file: common/adc_ctrl_pkg.sv
// register map, field positions and timing constants of the converter control block
package adc_ctrl_pkg;
    // ------------------------------------------------------------
    // register addresses and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_CONTROL   = 16'h0001;
    localparam logic [15:0] ADDR_GAIN      = 16'h0004;
    localparam logic [15:0] ADDR_THRESHOLD = 16'h0005;
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] GAIN_RESET     = 16'hA000;
    localparam logic [15:0] THRESH_RESET   = 16'hCCCC;
    // bits that may be stored; self-clearing and fixed-zero bits are left out
    localparam logic [15:0] CONTROL_KEEP   = 16'h008F;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CB_RD_THRESH = 14;
    localparam int CB_RD_GAIN   = 13;
    localparam int CB_RD_STATUS = 11;
    localparam int CB_SYNC      = 9;
    localparam int CB_BYPASS    = 7;
    localparam int CB_POWER_OFF_REQUEST  = 3;
    localparam int CB_LOW_POWER = 2;
    localparam int CB_REF_OFF   = 1;
    localparam int CB_AMPLIFIER_DISABLE   = 0;

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int SB_PART      = 15;
    localparam int SB_ONE_HI    = 14;
    localparam int SB_SETTLED   = 10;
    localparam int SB_OVR       = 8;
    localparam int SB_ONE_LO    = 6;
    localparam int SB_REF_ON    = 4;
    localparam int SB_AMP_ON    = 3;
    localparam int SB_LOW_POWER = 2;
    localparam int SB_DEC       = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          SYNC_MIN_LOW = 4;    // least low time of the sync pin, clock cycles
    localparam logic [2:0]  SYNC_CNT_TOP = 3'd4;
    localparam int          SETTLE_DEF   = 1024; // filter settling, clock cycles
endpackage

// file: bench/host_model.sv
// host controller model: sync pin, register writes and reads
`timescale 1ns/1ps
module host_model (
    // clock from the bench
    input  wire logic        clk,
    // lines toward the converter
    output logic             sync_n,
    output logic             wr_en,
    output logic      [15:0] wr_addr,
    output logic      [15:0] wr_data,
    output logic             rd_en,
    output logic      [31:0] conv_word
);
    // idle levels; sync stays high when no pulse is wanted
    initial
    begin
        sync_n    = 1'h1;
        wr_en     = 1'h0;
        wr_addr   = 16'h0000;
        wr_data   = 16'h0000;
        rd_en     = 1'h0;
        conv_word = 32'h0;
    end

    // address and 16-bit word; tasks run one at a time, so never during sync
    task automatic write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en   <= 1'h1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en   <= 1'h0;
        wr_addr <= ~a;  // released lines must not keep the last value
        wr_data <= ~d;
    endtask

    // one read strobe with a fresh conversion word
    task automatic read(input logic [31:0] cw);
        @(posedge clk);
        rd_en     <= 1'h1;
        conv_word <= cw;
        @(posedge clk);
        rd_en     <= 1'h0;
        conv_word <= ~cw;
    endtask

    // sync pulse n edges low; n of 4 or more unless a short one is meant
    task automatic sync_pulse(input int n);
        @(posedge clk);
        sync_n <= 1'h0;
        repeat (n) @(posedge clk);
        sync_n <= 1'h1;
    endtask
endmodule

// file: bench/test_adc_ctrl_regs.sv
// self-checking testbench of the control register block
`timescale 1ns/1ps
module test_adc_ctrl_regs;
    logic        clk;
    logic        arst_n;
    logic        overrange_in;
    logic [1:0]  dec_rate;
    wire         sync_n, wr_en, rd_en, rd_valid, filter_settled_flag, filter_restart;
    wire         power_off_request, low_power_flag, ref_buffer_off, ref_bypass, amplifier_disable;
    wire  [15:0] wr_addr, wr_data, gain_value, threshold_value;
    wire  [31:0] conv_word, rd_data;
    int          fail_count = 0;
    int          checks_done = 0;
    int          restarts = 0;
    logic [31:0] exp_q[$];
    logic [15:0] c;
    logic [15:0] v;

    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    adc_ctrl_regs #(.SETTLE_CYCLES(16)) dut_u (.clk(clk), .arst_n(arst_n), .sync_n(sync_n), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .conv_word(conv_word), .rd_data(rd_data),
        .rd_valid(rd_valid), .overrange_in(overrange_in), .dec_rate(dec_rate),
        .filter_settled_flag(filter_settled_flag), .power_off_request(power_off_request),
        .low_power_flag(low_power_flag), .ref_buffer_off(ref_buffer_off), .ref_bypass(ref_bypass),
        .amplifier_disable(amplifier_disable), .filter_restart(filter_restart), .gain_value(gain_value),
        .threshold_value(threshold_value));
    host_model host_u (.clk(clk), .sync_n(sync_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .conv_word(conv_word));

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // wait n edges, then let that edge's updates land
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // the note goes into the queue before the strobe, so the watcher always finds it
    task automatic rd_exp(input logic [31:0] e, input logic [31:0] cw);
        exp_q.push_back(e);
        host_u.read(cw);
    endtask
    function automatic logic [31:0] status(input logic [15:0] k);
        return {16'h0, 2'h3, 3'h0, 1'h1, 1'h0, overrange_in, 3'h2, ~k[1], ~k[0], k[2], dec_rate};
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watcher: each read answer is matched with the oldest note; restart pulses are counted
    always @(posedge clk)
    begin
        if (filter_restart === 1'h1)
            restarts++;
        if (rd_valid === 1'h1)
            chk("rd_data", (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx, rd_data);
    end

    // watchdog sized far beyond the roughly 120 cycles the run needs
    initial
    begin
        #20000;
        fail_count++;
        give_verdict();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        arst_n       = 1'h0; // clock already runs while reset is held low
        overrange_in = 1'h0;
        dec_rate     = 2'h0;
        void'($urandom(59));
        settle(16);
        chk("gain_rst", 32'hA000, {16'h0, gain_value});
        chk("thr_rst", 32'hCCCC, {16'h0, threshold_value});
        chk("ctrl_rst", 32'h0, {power_off_request, low_power_flag, ref_buffer_off, amplifier_disable});
        @(posedge clk);
        arst_n <= 1'h1;
        settle(10); // far more than two idle cycles before any access
        chk("settled_early", 32'h0, {31'h0, filter_settled_flag});
        settle(10);
        chk("settled", 32'h1, {31'h0, filter_settled_flag});
        $display("test reset and settling done");
        // random stored control bits plus fixed-zero bits left clear, then a status read
        // power-down forced on so the later sync finds the count frozen
        c = (16'($urandom()) & 16'h008F) | 16'h0008;
        @(posedge clk);
        overrange_in <= 1'($urandom());
        dec_rate     <= 2'($urandom());
        host_u.write(16'h0001, c);
        #1;
        chk("ctrl_out", {27'h0, c[7], c[3:0]}, {27'h0, ref_bypass, power_off_request, low_power_flag,
            ref_buffer_off, amplifier_disable});
        host_u.write(16'h0001, c | 16'h0800);
        rd_exp(status(c), 32'($urandom()));
        v = 16'($urandom());
        rd_exp({v, ~v}, {v, ~v});
        $display("test control and status done");
        // gain then threshold: store, read back through its select, stray address ignored
        for (int i = 0; i < 2; i++)
        begin
            v = 16'($urandom());
            host_u.write(16'h0004 + 16'(i), v);
            settle(1);
            chk("reg_val", {16'h0, v}, {16'h0, (i == 0) ? gain_value : threshold_value});
            host_u.write(16'h0001, c | ((i == 0) ? 16'h2000 : 16'h4000));
            rd_exp({16'h0, v}, 32'($urandom()));
            host_u.write(16'h0002, ~v);
            settle(1);
            chk("stray", {16'h0, v}, {16'h0, (i == 0) ? gain_value : threshold_value});
        end
        $display("test gain and threshold done");
        // short sync ignored, full sync restarts, control sync bit restarts once
        v = 16'(restarts);
        host_u.sync_pulse(3);
        settle(4);
        chk("short_sync", {16'h0, v}, 32'(restarts));
        host_u.sync_pulse(4);
        settle(3);
        chk("sync", {16'h0, v + 16'h1}, 32'(restarts));
        chk("unsettled", 32'h0, {31'h0, filter_settled_flag});
        host_u.write(16'h0001, 16'h0200);
        settle(3);
        chk("ctrl_sync", {16'h0, v + 16'h2}, 32'(restarts));
        chk("pwr_up", 32'h0, {31'h0, power_off_request});
        settle(20);
        chk("resettled", 32'h1, {31'h0, filter_settled_flag});
        $display("test sync done");
        // mid-run reset: registers fall back to defaults and settling starts over
        @(posedge clk);
        arst_n <= 1'h0;
        settle(2);
        chk("gain_rst2", 32'hA000, {16'h0, gain_value});
        chk("thr_rst2", 32'hCCCC, {16'h0, threshold_value});
        chk("settled_rst", 32'h0, {31'h0, filter_settled_flag});
        @(posedge clk);
        arst_n <= 1'h1;
        settle(2);
        rd_exp(32'h1234_5678, 32'h1234_5678);
        $display("test mid-run reset done");
        settle(4);
        chk("queue", 32'h0, 32'(exp_q.size()));
        give_verdict();
    end
endmodule
